/* pcs_irq_status_ctrl.sv */
// interrupt routing, card control and status-change flags of one socket
// assumes card pins are asynchronous and the register port is on sys_clk
//
// Operation
// - bit 7 enables ring indicate on detect-1 for an I/O card
// - card reset asserted while bit 6 is 0
// - bit 5 picks memory or I/O card
// - bit 4 sends status interrupts to PCI
// - bits 3..0 route functional card interrupt of an I/O card
// - disabled source reads 0; enabled shows activity
// - flags clear by read or write-one, selectable
// - status bits 7..4 read as zero
// - bit 3 set on either card-detect change
// - memory card: bit 2 on ready rise
// - I/O card: bits 2 and 1 stay 0
// - memory card: bit 1 on battery low
// - bit 0: battery dead or status asserted
// - ring mode: bit 0 follows ring input
// - battery detect: 0x dead, 10 low, 11 good
// - detect event only with detect enable set
`timescale 1ns/10ps
`include "pcs_cfg.svh"
module pcs_irq_status_ctrl
  import pcs_pkg::*;
(
  input  wire logic       sys_clk,                   // 125 MHz clock
  input  wire logic       rst_n,                     // async reset
  input  wire logic [7:0] reg_addr,                  // register offset
  input  wire logic       reg_wr,                    // write strobe
  input  wire logic       reg_rd,                    // read strobe
  input  wire logic [7:0] reg_wdata,                 // write data
  output logic      [7:0] reg_rdata,                 // read data, next clk
  input  wire logic       card_detect_event_enable,  // detect source on
  input  wire logic       ready_event_enable,        // ready source on
  input  wire logic       battery_warn_event_enable, // battery-low on
  input  wire logic       battery_dead_event_enable, // dead/status on
  input  wire logic [3:0] status_irq_line_select,    // status line code
  input  wire logic       flag_clear_by_write,       // 1: write-one clear
  input  wire logic       card_detect1_n,            // card pin
  input  wire logic       card_detect2_n,            // card pin
  input  wire logic       card_ready,                // card pin
  input  wire logic       battery_detect1,           // detect-1/status/ring
  input  wire logic       battery_detect2,           // detect-2 pin
  input  wire logic       card_irq_n,                // functional request
  output logic            card_reset_out,            // card reset, high
  output logic            pci_irq,                   // status irq to PCI
  output logic     [15:0] irq_route                  // line n; bit 2 is SMI
);

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] line_decode(input pcs_line_sel_t code);
    logic [15:0] v;
    v = 16'h0000;
    if (code != `PCS_SEL_NONE) begin
      v[code] = 1'b1;
    end
    return v;
  endfunction : line_decode

  function automatic logic is_dead(input logic [1:0] bvd);
    return (bvd[1] == 1'b0);
  endfunction : is_dead

  //////////////////////////////////////////////////////////////////////////
  logic [5:0] pins_s;
  logic [1:0] cd_s;
  logic       ready_s;
  logic [1:0] bvd_s;
  logic       irq_n_s;

  pcs_sync #(.WIDTH(6)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  ({card_irq_n, battery_detect2, battery_detect1, card_ready,
               card_detect2_n, card_detect1_n}),
    .pin_out (pins_s)
  );

  assign cd_s    = pins_s[1:0];
  assign ready_s = pins_s[2];
  assign bvd_s   = pins_s[4:3];
  assign irq_n_s = pins_s[5];

  //////////////////////////////////////////////////////////////////////////
  logic [7:0]  ctrl, next_ctrl;
  logic [3:0]  flags, next_flags;
  logic [1:0]  cd_prev, bvd_prev;
  logic        ready_prev;
  logic [1:0]  arm_cnt, next_arm_cnt;
  logic [7:0]  next_rdata;
  logic        next_reset_out, next_pci;
  logic [15:0] next_route;

  pcs_card_kind_t kind;
  logic        armed, ring_mode, to_pci, any_flag;
  logic        rd_flags, wr_flags;
  logic [3:0]  ev, en_mask, clr, flags_rd;

  assign kind      = pcs_card_kind_t'(ctrl[`PCS_BIT_CARD_KIND]);
  assign armed     = (arm_cnt == `PCS_ARM_DONE);
  assign ring_mode = ctrl[`PCS_BIT_RING_EN] && kind == PCS_CARD_IO;
  assign to_pci    = ctrl[`PCS_BIT_PCI_ROUTE] ||
                     ctrl[`PCS_SEL_HI:`PCS_SEL_LO] == `PCS_SEL_NONE;
  assign rd_flags  = reg_rd && reg_addr == `PCS_OFS_FLAGS;
  assign wr_flags  = reg_wr && reg_addr == `PCS_OFS_FLAGS;
  assign en_mask   = {card_detect_event_enable, ready_event_enable,
                      battery_warn_event_enable, battery_dead_event_enable};

  // events; edge detect waits for the synchroniser to fill after reset
  always_comb begin
    ev = 4'h0;
    ev[`PCS_FLG_DETECT] = armed && card_detect_event_enable &&
                          cd_s != cd_prev;
    ev[`PCS_FLG_READY]  = armed && ready_event_enable &&
                          kind == PCS_CARD_MEMORY &&
                          ready_s && !ready_prev;
    ev[`PCS_FLG_BATLOW] = armed && battery_warn_event_enable &&
                          kind == PCS_CARD_MEMORY &&
                          bvd_s == `PCS_BVD_LOW &&
                          bvd_prev != `PCS_BVD_LOW;
    if (kind == PCS_CARD_MEMORY) begin
      ev[`PCS_FLG_BATTERY_DEAD_FLAG] = armed && battery_dead_event_enable &&
                             is_dead(bvd_s) && !is_dead(bvd_prev);
    end else begin
      ev[`PCS_FLG_BATTERY_DEAD_FLAG] = armed && battery_dead_event_enable &&
                             !ring_mode && !bvd_s[0] && bvd_prev[0];
    end
  end

  // flag view seen by software and by the interrupt logic
  always_comb begin
    flags_rd = flags & en_mask;
    if (ring_mode) begin
      flags_rd[`PCS_FLG_BATTERY_DEAD_FLAG] = battery_dead_event_enable &&
                                   !bvd_s[0];
    end
  end
  assign any_flag = |flags_rd;

  //////////////////////////////////////////////////////////////////////////
  // a set in the same cycle as a clear wins, so no event is lost
  always_comb begin
    clr = 4'h0;
    if (rd_flags && !flag_clear_by_write) begin
      clr = 4'hF;
    end else if (wr_flags && flag_clear_by_write) begin
      clr = reg_wdata[3:0];
    end
    next_flags = (flags & ~clr) | ev;
    if (kind == PCS_CARD_IO) begin
      next_flags[`PCS_FLG_READY]  = 1'b0;
      next_flags[`PCS_FLG_BATLOW] = 1'b0;
    end
    if (ring_mode) begin
      next_flags[`PCS_FLG_BATTERY_DEAD_FLAG] = 1'b0;
    end
  end

  always_comb begin
    next_ctrl = ctrl;
    if (reg_wr && reg_addr == `PCS_OFS_CTRL) begin
      next_ctrl = reg_wdata;
    end
    next_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        `PCS_OFS_CTRL:  next_rdata = ctrl;
        `PCS_OFS_FLAGS: next_rdata = {4'h0, flags_rd};
        default:        next_rdata = 8'h00;
      endcase
    end
    next_arm_cnt = armed ? arm_cnt : arm_cnt + 2'h1;
  end

  always_comb begin
    next_reset_out = !ctrl[`PCS_BIT_RESET_REL];
    next_pci       = any_flag && to_pci;
    next_route     = 16'h0000;
    if (any_flag && !to_pci) begin
      next_route = line_decode(status_irq_line_select);
    end
    if (kind == PCS_CARD_IO && !irq_n_s) begin
      next_route = next_route |
                   line_decode(ctrl[`PCS_SEL_HI:`PCS_SEL_LO]);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl           <= `PCS_CTRL_RESET;
      flags          <= `PCS_FLAGS_RESET;
      cd_prev        <= 2'h0;
      bvd_prev       <= 2'h0;
      ready_prev     <= 1'b0;
      arm_cnt        <= 2'h0;
      reg_rdata      <= 8'h00;
      card_reset_out <= 1'b1;
      pci_irq        <= 1'b0;
      irq_route      <= 16'h0000;
    end else begin
      ctrl           <= next_ctrl;
      flags          <= next_flags;
      cd_prev        <= cd_s;
      bvd_prev       <= bvd_s;
      ready_prev     <= ready_s;
      arm_cnt        <= next_arm_cnt;
      reg_rdata      <= next_rdata;
      card_reset_out <= next_reset_out;
      pci_irq        <= next_pci;
      irq_route      <= next_route;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  reset_level_a: assert property (
    ctrl[`PCS_BIT_RESET_REL] ##1 ctrl[`PCS_BIT_RESET_REL] |=> !card_reset_out)
    else $error("card reset asserted while release bit set");

  rsvd_zero_a: assert property (
    rd_flags |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved status bits not zero");

  disabled_zero_a: assert property (
    rd_flags && !card_detect_event_enable |=> !reg_rdata[3])
    else $error("disabled detect source read as set");

  io_quiet_a: assert property (
    kind == PCS_CARD_IO && $past(kind == PCS_CARD_IO) |-> flags[2:1] == 2'h0)
    else $error("ready or battery-low flag set on I/O card");

  ready_set_a: assert property (
    ev[`PCS_FLG_READY] ##1 kind == PCS_CARD_MEMORY |-> flags[`PCS_FLG_READY])
    else $error("ready rise not flagged");

  set_wins_a: assert property (
    ev[`PCS_FLG_DETECT] && clr[`PCS_FLG_DETECT] |=> flags[`PCS_FLG_DETECT])
    else $error("detect event lost to a clear");

  read_clear_a: assert property (
    rd_flags && !flag_clear_by_write && ev == 4'h0 |=> flags == 4'h0)
    else $error("read did not clear flags");

  w1c_a: assert property (
    wr_flags && flag_clear_by_write && reg_wdata[3] && !ev[3]
    |=> !flags[`PCS_FLG_DETECT])
    else $error("write-one did not clear detect flag");

  pci_route_a: assert property (
    any_flag && to_pci |=> pci_irq)
    else $error("status interrupt not routed to PCI");

  detect_gate_a: assert property (
    !card_detect_event_enable && !flags[3] && !clr[3] |=> !flags[3])
    else $error("detect flag set while disabled");

  // event, then flag, then the registered interrupt
  detect_cv: cover property (ev[`PCS_FLG_DETECT] ##2 pci_irq);
  ring_cv: cover property (ring_mode && flags_rd[`PCS_FLG_BATTERY_DEAD_FLAG]);
  func_cv: cover property (kind == PCS_CARD_IO && irq_route != 16'h0000);

endmodule : pcs_irq_status_ctrl

/* pcs_cfg.svh */
// constants for the card interrupt/status block: offsets, fields, resets
// assumes an 8-bit register port addressed by socket register offset
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

`define PCS_OFS_CTRL        8'h03
`define PCS_OFS_FLAGS       8'h04

`define PCS_CTRL_RESET      8'h00
`define PCS_FLAGS_RESET     4'h0

`define PCS_BIT_RING_EN     7
`define PCS_BIT_RESET_REL   6
`define PCS_BIT_CARD_KIND   5
`define PCS_BIT_PCI_ROUTE   4
`define PCS_SEL_HI          3
`define PCS_SEL_LO          0

`define PCS_FLG_DETECT      3
`define PCS_FLG_READY       2
`define PCS_FLG_BATLOW      1
`define PCS_FLG_BATTERY_DEAD_FLAG     0

`define PCS_SEL_NONE        4'h0
`define PCS_BVD_LOW         2'h2
`define PCS_ARM_DONE        2'h3

`endif

/* pcs_pkg.sv */
// shared types for the card interrupt/status block
// assumes nothing beyond a SystemVerilog tool
package pcs_pkg;
  typedef enum logic {
    PCS_CARD_MEMORY = 1'b0,
    PCS_CARD_IO     = 1'b1
  } pcs_card_kind_t;

  typedef logic [3:0] pcs_line_sel_t;
endpackage : pcs_pkg

/* pcs_sync.sv */
// two-stage synchroniser for a vector of independent card pins
// assumes each bit is a slow level; no multi-bit coherence is promised
`timescale 1ns/10ps
module pcs_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             sys_clk, // system clock
  input  wire logic             rst_n,   // async reset, active low
  input  wire logic [WIDTH-1:0] pin_in,  // raw pin levels
  output logic      [WIDTH-1:0] pin_out  // synchronised levels
);
  logic [WIDTH-1:0] stage1;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1[g]  <= 1'b0;
          pin_out[g] <= 1'b0;
        end else begin
          stage1[g]  <= pin_in[g];
          pin_out[g] <= stage1[g];
        end
      end
    end
  endgenerate
endmodule : pcs_sync

/* pcs_card_model.sv */
// card model: pin levels of a 16-bit card in the socket
// assumes the bench calls put just after a clock edge
`timescale 1ns/10ps
module pcs_card_model (
  input  wire logic sys_clk, // lag reference
  output logic      cd1_n,   // detect 1
  output logic      cd2_n,   // detect 2
  output logic      rdy,     // ready
  output logic      bvd1,    // detect-1/status/ring
  output logic      bvd2,    // detect-2
  output logic      irq_n    // functional request
);
  initial {cd1_n, cd2_n, rdy, bvd1, bvd2, irq_n} = 6'h0F;
  // pins move just after the next edge; a slow card waits lag more
  task automatic put(input logic [5:0] v, input int lag);
    repeat (lag + 1) @(posedge sys_clk);
    #1 {cd1_n, cd2_n, rdy, bvd1, bvd2, irq_n} = v;
  endtask : put
endmodule : pcs_card_model

/* pcs_irq_status_ctrl_tb_top.sv */
// bench: registers, card pins and routed irqs against a model
// assumes card model pins are {cd1_n,cd2_n,rdy,bvd1,bvd2,irq_n}
`timescale 1ns/10ps
module pcs_irq_status_ctrl_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [3:0]  en = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic        wclr = 1'b0;
  logic        cd1_n, cd2_n, rdy, bvd1, bvd2, irq_n;
  logic        card_reset_out, pci_irq;
  logic [15:0] irq_route;
  int          fail_count = 0;
  int          checks = 0;
  int          mflags = 0;
  int          ctrl = 0;
  always #4 sys_clk = ~sys_clk;
  pcs_irq_status_ctrl pcs_irq_status_ctrl_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .card_detect_event_enable(en[3]),
    .ready_event_enable(en[2]), .battery_warn_event_enable(en[1]),
    .battery_dead_event_enable(en[0]), .status_irq_line_select(sel),
    .flag_clear_by_write(wclr), .card_detect1_n(cd1_n),
    .card_detect2_n(cd2_n), .card_ready(rdy), .battery_detect1(bvd1),
    .battery_detect2(bvd2), .card_irq_n(irq_n),
    .card_reset_out(card_reset_out), .pci_irq(pci_irq),
    .irq_route(irq_route));
  pcs_card_model pcs_card_model_i (
    .sys_clk(sys_clk), .cd1_n(cd1_n), .cd2_n(cd2_n), .rdy(rdy),
    .bvd1(bvd1), .bvd2(bvd2), .irq_n(irq_n));
  ////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(logic wr, logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : acc
  task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
    acc(1'b0, a, 8'h00);
    chk(nm, {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd
  task automatic wctl(int v);
    ctrl = v;
    acc(1'b1, 8'h03, v[7:0]);
  endtask : wctl
  // pin change, then long enough for sync, flag and irq
  task automatic pin(logic [5:0] v, int lag);
    pcs_card_model_i.put(v, lag);
    repeat (8) @(posedge sys_clk);
    #1;
  endtask : pin
  task automatic irqchk();
    logic [15:0] r;
    logic        act;
    logic        topci;
    r = 16'h0000;
    act = (mflags & en) != 0;
    topci = ctrl[4] || ctrl[3:0] == 0;
    if (act && !topci && sel != 0)
      r[sel] = 1'b1;
    if (ctrl[5] && !irq_n && ctrl[3:0] != 0)
      r[ctrl[3:0]] = 1'b1;
    chk("pci_irq", {15'h0, act && topci}, {15'h0, pci_irq});
    chk("irq_route", r, irq_route);
  endtask : irqchk
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hc95bd1c0));
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("card_reset_out", 16'h1, {15'h0, card_reset_out});
    irqchk();
    rd(8'h03, 8'h00, "ctrl");
    rd(8'h04, 8'h00, "flags");
    rd(8'h07, 8'h00, "unmapped");
    for (int i = 0; i < 6; i++) begin
      wctl($urandom & 32'hFF);
      acc(1'b1, 8'h06, 8'hFF);
      rd(8'h03, ctrl[7:0], "ctrl");
      chk("card_reset_out", {15'h0, !ctrl[6]}, {15'h0, card_reset_out});
      irqchk();
    end
    wctl(8'h40);
    en = 4'hF;
    sel = 4'h5;
    pin(6'h07, 0);
    pin(6'h0F, 3);
    mflags = 4;
    irqchk();
    wctl(8'h41);
    irqchk();
    wctl(8'h51);
    irqchk();
    rd(8'h04, 8'h04, "flags");
    mflags = 0;
    rd(8'h04, 8'h00, "flags");
    irqchk();
    pin(6'h0B, 0);
    pin(6'h09, 0);
    rd(8'h04, 8'h03, "flags");
    pin(6'h0F, 0);
    wclr = 1'b1;
    pin(6'h2F, 0);
    mflags = 8;
    rd(8'h04, 8'h08, "flags");
    rd(8'h04, 8'h08, "flags");
    acc(1'b1, 8'h04, 8'h08);
    mflags = 0;
    rd(8'h04, 8'h00, "flags");
    wclr = 1'b0;
    pin(6'h0F, 0);
    rd(8'h04, 8'h08, "flags");
    wctl(8'h60);
    pin(6'h07, 0);
    pin(6'h0F, 0);
    pin(6'h0B, 2);
    mflags = 1;
    irqchk();
    rd(8'h04, 8'h01, "flags");
    mflags = 0;
    pin(6'h0E, 0);
    for (int i = 1; i < 16; i++) begin
      wctl(8'h60 | i);
      repeat (3) @(posedge sys_clk);
      #1;
      irqchk();
    end
    wctl(8'hE0);
    en = 4'h1;
    pin(6'h0B, 0);
    rd(8'h04, 8'h01, "ring");
    pin(6'h0F, 0);
    rd(8'h04, 8'h00, "ring");
    wctl(8'h40);
    en = 4'h7;
    pin(6'h2F, 0);
    rd(8'h04, 8'h00, "masked");
    // detect change lands in the very cycle of a clearing read
    en = 4'hF;
    fork
      pcs_card_model_i.put(6'h0F, 0);
      begin
        repeat (2) @(posedge sys_clk);
        rd(8'h04, 8'h00, "flags");
      end
    join
    rd(8'h04, 8'h08, "set_wins");
    // mid-run reset with ready high: no false rise once armed
    rst_n = 1'b0;
    ctrl = 0;
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    chk("card_reset_out", 16'h1, {15'h0, card_reset_out});
    irqchk();
    rd(8'h04, 8'h00, "flags");
    rd(8'h03, 8'h00, "ctrl");
    end_sim();
  end
endmodule : pcs_irq_status_ctrl_tb_top
